// ---- rtl/burst_sram_cycle.sv ----
// Cycle control, burst counter, lane masking and array of the pipelined burst SRAM
`timescale 1ns/10ps
`default_nettype none

module burst_sram_cycle
   import burst_sram_pkg::*;
(
   input  wire logic                i_clock,                 // 200 MHz
   input  wire logic                i_rst_n,                 // Async, active low
   input  wire logic                i_chip_en1_n,            // Chip enable, active low
   input  wire logic                i_chip_en2,              // Chip enable, active high
   input  wire logic                i_chip_en3_n,            // Chip enable, active low
   input  wire logic                i_clock_qualifier_n,     // Low: edge recognised
   input  wire logic                i_advance_or_load,       // High advance, low load
   input  wire logic                i_write_en_n,            // Low: write
   input  wire logic [LANES-1:0]    i_byte_lane_selects_n,   // Active-low lane selects
   input  wire logic [ADDR_W-1:0]   i_addr,                  // External address
   input  wire logic                i_burst_order,           // Low linear, high interleaved
   input  wire logic                i_output_gate_n,         // Output gate, active low
   input  wire logic [DATA_W-1:0]   i_data,                  // Data pins, inward
   output var  logic [DATA_W-1:0]   o_data,                  // Data pins, outward
   output var  logic                o_data_oe,               // Data pins driven
   input  wire logic [LANES-1:0]    i_parity_pins,           // Parity pins, inward
   output var  logic [LANES-1:0]    o_parity_pins,           // Parity pins, outward
   output var  logic                o_parity_pins_oe         // Parity pins driven
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Low address bits for a given burst step
   function automatic logic [BURST_W-1:0] burst_low(input logic [BURST_W-1:0] start,
                                                    input logic [BURST_W-1:0] count,
                                                    input logic               order);
      begin
         if (order)
            burst_low = start ^ count;                        // Interleaved
         else
            burst_low = BURST_W'(start + count);              // Linear, wraps
      end
   endfunction : burst_low

   cycle_state_t             st_reg;      // Registered state
   cycle_state_t             st_next;     // Its next value
   logic                     recognised;  // This edge counts
   logic                     all_ce;      // All three enables active
   logic                     mem_we;      // Array write at this edge
   logic [LANES-1:0]         lane_we;     // Lanes written at this edge
   logic [LANE_W-1:0]        rd_lane [LANES];  // Read word per lane, bypass applied
   logic [DATA_W-1:0]        rd_data;     // Read data assembled
   logic [LANES-1:0]         rd_parity;   // Read parity assembled
   logic [BURST_W-1:0]       step;        // Burst count after this advance

   assign recognised = !i_clock_qualifier_n;
   assign all_ce     = !i_chip_en1_n && i_chip_en2 && !i_chip_en3_n;
   // Write data is taken two recognised edges after the command
   assign mem_we     = recognised && st_reg.s2_valid;
   assign step       = BURST_W'(st_reg.burst_count + BURST_STEP);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Array, one bank per lane so that masking needs no read-modify-write

   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : g_lane
         logic [LANE_W-1:0] lane_mem [0:MEM_DEPTH-1];  // Lane storage, no reset
         logic [LANE_W-1:0] lane_in;                   // Incoming lane word

         assign lane_in    = {i_parity_pins[g], i_data[g*BYTE_W +: BYTE_W]};
         assign lane_we[g] = mem_we && !st_reg.s2_lanes[g];

         // Store only selected lanes; others stay unaltered
         always_ff @(posedge i_clock)
         begin
            if (lane_we[g])
               lane_mem[st_reg.s2_addr] <= lane_in;
         end

         // A read right behind a write to the same word sees the new data
         assign rd_lane[g] = (lane_we[g] && st_reg.s2_addr == st_reg.s1_addr)
                             ? lane_in : lane_mem[st_reg.s1_addr];
      end
   endgenerate

   // Unpack lanes into data and parity
   always_comb
   begin
      rd_data   = '0;
      rd_parity = '0;
      for (int k = 0; k < LANES; k++)
      begin
         rd_data[k*BYTE_W +: BYTE_W] = rd_lane[k][BYTE_W-1:0];
         rd_parity[k]                = rd_lane[k][BYTE_W];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Cycle decode and pipeline

   // Next state; an unrecognised edge keeps everything as it is
   always_comb
   begin
      st_next = st_reg;                                      // Wait state
      if (recognised)
      begin
         // Second stage: write waits for its data, read fills the output register
         st_next.s2_valid = st_reg.s1_valid && st_reg.s1_write;
         st_next.s2_addr  = st_reg.s1_addr;
         st_next.s2_lanes = st_reg.s1_lanes;
         // Drivers only for a read, gated, never in a write's data cycle
         st_next.drive    = st_reg.s1_valid && !st_reg.s1_write && !i_output_gate_n;
         if (st_reg.s1_valid && !st_reg.s1_write)
         begin
            st_next.data_out   = rd_data;
            st_next.parity_out = rd_parity;
         end
         // First stage: decode the command of this edge
         if (!i_advance_or_load)
         begin
            if (all_ce)
            begin
               // Load a new address and start an access
               st_next.s1_valid    = 1'b1;
               st_next.s1_write    = !i_write_en_n;
               st_next.s1_addr     = i_addr;
               st_next.s1_lanes    = i_write_en_n ? LANES_NONE : i_byte_lane_selects_n;
               st_next.burst_start = i_addr[BURST_W-1:0];
               st_next.burst_count = '0;
               st_next.state       = i_write_en_n ? ST_READ : ST_WRITE;
            end
            else
            begin
               // Deselect; floats after the next recognised edge
               st_next.s1_valid = 1'b0;
               st_next.s1_write = 1'b0;
               st_next.state    = ST_DESEL;
            end
         end
         else
         begin
            // Advance: enables and write strobe ignored
            case (st_reg.state)
               ST_READ, ST_WRITE:
               begin
                  st_next.s1_valid    = 1'b1;
                  st_next.s1_write    = (st_reg.state == ST_WRITE);
                  st_next.burst_count = step;
                  st_next.s1_addr     = {st_reg.s1_addr[ADDR_W-1:BURST_W],
                                         burst_low(st_reg.burst_start, step, i_burst_order)};
                  st_next.s1_lanes    = (st_reg.state == ST_WRITE)
                                        ? i_byte_lane_selects_n : LANES_NONE;
               end
               default:
               begin
                  // No access to continue; stay deselected
                  st_next.s1_valid = 1'b0;
                  st_next.s1_write = 1'b0;
               end
            endcase
         end
      end
   end

   // State register; reset gives the deselected, floating device
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         st_reg <= STATE_RESET;
      else
         st_reg <= st_next;
   end

   assign o_data           = st_reg.data_out;
   assign o_data_oe        = st_reg.drive;
   assign o_parity_pins    = st_reg.parity_out;
   assign o_parity_pins_oe = st_reg.drive;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   sequence load_read_s;
      recognised && !i_advance_or_load && all_ce && i_write_en_n;
   endsequence

   sequence load_write_s;
      recognised && !i_advance_or_load && all_ce && !i_write_en_n;
   endsequence

   sequence deselect_s;
      recognised && !i_advance_or_load && !all_ce;
   endsequence

   deselect_float_a: assert property (deselect_s ##1 recognised |=> !o_data_oe)
      else $error("Pins still driven after deselect");
   suspend_hold_a: assert property (!recognised |=> $stable(st_reg))
      else $error("State moved on an ignored edge");
   write_commit_a: assert property (load_write_s ##1 recognised ##1 recognised |-> mem_we)
      else $error("Write data not taken two edges after command");
   burst_read_a: assert property (recognised && i_advance_or_load
      && st_reg.state == ST_READ |=> st_reg.s1_valid && !st_reg.s1_write)
      else $error("Burst read did not continue");
   burst_write_a: assert property (recognised && i_advance_or_load
      && st_reg.state == ST_WRITE
      |=> st_reg.s1_write && st_reg.s1_lanes == $past(i_byte_lane_selects_n))
      else $error("Burst write lost its lane selects");
   linear_step_a: assert property (recognised && i_advance_or_load && !i_burst_order
      && st_reg.state != ST_DESEL
      |=> st_reg.s1_addr[1:0] == 2'($past(st_reg.s1_addr[1:0]) + 2'h1))
      else $error("Linear burst step wrong");
   // Next low bits are the load's low bits XOR the count after this advance
   interleave_step_a: assert property (recognised && i_advance_or_load && i_burst_order
      && st_reg.state != ST_DESEL
      |=> st_reg.s1_addr[1:0] == ($past(st_reg.burst_start)
                                  ^ 2'($past(st_reg.burst_count) + 2'h1)))
      else $error("Interleaved burst step wrong");
   lane_mask_a: assert property (st_reg.s2_lanes == LANES_NONE |-> lane_we == '0)
      else $error("Lane written while unselected");
   gate_off_a: assert property (o_data_oe |-> $past(!i_output_gate_n))
      else $error("Driving with output gate high");
   read_drive_a: assert property (load_read_s ##1 (recognised && !i_output_gate_n)
      |=> o_data_oe && o_parity_pins_oe)
      else $error("Read data not driven");
   write_float_a: assert property (load_write_s ##1 recognised |=> !o_data_oe)
      else $error("Drivers on in write data cycle");

   reset_float_a: assert property (@(posedge i_clock) disable iff (1'b0)
      $rose(i_rst_n) |-> !o_data_oe && !o_parity_pins_oe)
      else $error("Pins driven at reset release");

endmodule : burst_sram_cycle

`default_nettype wire

// ---- rtl/burst_sram_pkg.sv ----
// Constants, state encodings and the state record for the burst SRAM cycle control
// Contract
// - Chip enable off with load: deselect, float
// - Qualifier high: edge ignored, all state held
// - Full enables plus load: latch address, start access
// - Advance after read: next burst read, internal address
// - Advance after write: burst write, lanes per cycle
// - Burst steps low bits linear or interleaved
// - Active-low lane selects choose bytes written
// - Pins follow current cycle and output gate
// - Starts deselected with pins floating
// - Read data driven edge after address latch
// - Write data portion always turns drivers off
// - One address serves four accesses, counter wraps
package burst_sram_pkg;

   localparam int ADDR_W    = 18;             // Word address width
   localparam int DATA_W    = 16;             // Data pins
   localparam int LANES     = 2;              // Byte lanes, one parity pin each
   localparam int BYTE_W    = 8;              // Data bits per lane
   localparam int LANE_W    = BYTE_W + 1;     // Lane word with its parity bit
   localparam int BURST_W   = 2;              // Low address bits stepped by a burst
   localparam int MEM_DEPTH = 1 << ADDR_W;    // Words in the array

   localparam logic [LANES-1:0]   LANES_NONE = 2'h3;  // Active-low: no lane written
   localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;  // Counter increment

   // Kind of the last access that a burst may continue
   typedef enum logic [1:0]
   {
      ST_DESEL = 2'b00,
      ST_READ  = 2'b01,
      ST_WRITE = 2'b10
   } access_t;

   // Whole state of the cycle control, registered as one word
   typedef struct packed
   {
      access_t              state;        // Access a burst continues
      logic                 s1_valid;     // Access latched, array stage pending
      logic                 s1_write;     // Latched access is a write
      logic [ADDR_W-1:0]    s1_addr;      // Address in use this cycle
      logic [LANES-1:0]     s1_lanes;     // Lane selects latched with it
      logic [BURST_W-1:0]   burst_start;  // Low bits of the loaded address
      logic [BURST_W-1:0]   burst_count;  // Steps taken since the load
      logic                 s2_valid;     // Write waiting for its data
      logic [ADDR_W-1:0]    s2_addr;      // Address of that write
      logic [LANES-1:0]     s2_lanes;     // Lane selects of that write
      logic [DATA_W-1:0]    data_out;     // Output register, data
      logic [LANES-1:0]     parity_out;   // Output register, parity
      logic                 drive;        // Output drivers on
   } cycle_state_t;

   localparam cycle_state_t STATE_RESET = '0;  // Deselected, drivers off

endpackage : burst_sram_pkg

// ---- testbench/sram_ctrl_model.sv ----
// Memory controller model: drives the cycle control pins and owes write data
`timescale 1ns/10ps
`default_nettype none

module sram_ctrl_model
   import burst_sram_pkg::*;
(
   input  wire logic                     i_clock,               // Shared clock
   output var  logic [2:0]               o_chip_en,             // {en1_n, en2, en3_n}
   output var  logic                     o_clock_qualifier_n,   // High: edge ignored
   output var  logic                     o_advance_or_load,     // High advance, low load
   output var  logic                     o_write_en_n,          // Low: write
   output var  logic [LANES-1:0]         o_byte_lane_selects_n, // Active-low lanes
   output var  logic [ADDR_W-1:0]        o_addr,                // Address pins
   output var  logic [LANES+DATA_W-1:0]  o_wdata                // {parity, data} driven in
);
   logic [LANES+DATA_W-1:0]  wd_reg;    // Data of the command now on the pins
   logic                     wv_reg;    // Command now on the pins carries write data
   logic [LANES+DATA_W-1:0]  pend_reg;  // Data owed one recognised edge later
   logic                     pend_v;    // Pending data is real

   initial
   begin
      o_chip_en = 3'b101;
      o_clock_qualifier_n = 1'b0;
      o_advance_or_load = 1'b0;
      o_write_en_n = 1'b1;
      o_byte_lane_selects_n = 2'h3;
      o_addr = '0;
      o_wdata = '0;
      wd_reg = '0;
      wv_reg = 1'b0;
      pend_v = 1'b0;
      pend_reg = '0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Write data goes out two recognised edges after its command; when nothing is
   // owed the bus toggles, so a design that samples a stale bus is caught
   always @(posedge i_clock)
   begin
      if (!o_clock_qualifier_n)
      begin
         pend_v <= wv_reg;
         pend_reg <= wd_reg;
         o_wdata <= pend_v ? pend_reg : ~o_wdata;
      end
   end

   // One command per edge, changed just after the edge and held through the next
   task automatic cmd(input logic [2:0] ce, input logic cq, input logic adv, input logic we,
                      input logic [1:0] lanes, input logic [17:0] a,
                      input logic [17:0] wd, input logic wv);
      o_chip_en = ce;
      o_clock_qualifier_n = cq;
      o_advance_or_load = adv;
      o_write_en_n = we;
      o_byte_lane_selects_n = lanes;
      o_addr = a;
      wd_reg = wd;
      wv_reg = wv;
      @(posedge i_clock);
      #1;
   endtask : cmd
endmodule : sram_ctrl_model
`default_nettype wire

// ---- testbench/tb_burst_sram_cycle.sv ----
// Self-checking bench for the burst SRAM cycle control
`timescale 1ns/10ps
`default_nettype none

module tb_burst_sram_cycle;
   import burst_sram_pkg::*;
   logic         clock, rst_n, order, gate_n;   // Bench-driven inputs
   logic [2:0]   ce;                            // Chip enables from the model
   logic         cq_n, adv, we_n;               // Controls from the model
   logic [1:0]   lanes_n, par, par_o;           // Lanes, parity bus and parity out
   logic [17:0]  addr, wdata;                   // Address and controller data
   logic [15:0]  dq, dq_o;                      // Data bus and data out
   logic         oe, poe;                       // Design driver enables
   logic [17:0]  mem [logic [17:0]];            // Expected array contents
   int           fail_count, checks, cycles;

   // Shared wire: whoever enables drives, else the controller's value
   assign dq = oe ? dq_o : wdata[15:0];
   assign par = poe ? par_o : wdata[17:16];

   initial clock = 1'b0;
   always #2.5 clock = ~clock;

   sram_ctrl_model sram_ctrl_model_i (.i_clock(clock), .o_chip_en(ce),
      .o_clock_qualifier_n(cq_n), .o_advance_or_load(adv), .o_write_en_n(we_n),
      .o_byte_lane_selects_n(lanes_n), .o_addr(addr), .o_wdata(wdata));

   burst_sram_cycle burst_sram_cycle_i (.i_clock(clock), .i_rst_n(rst_n),
      .i_chip_en1_n(ce[2]), .i_chip_en2(ce[1]), .i_chip_en3_n(ce[0]),
      .i_clock_qualifier_n(cq_n), .i_advance_or_load(adv), .i_write_en_n(we_n),
      .i_byte_lane_selects_n(lanes_n), .i_addr(addr), .i_burst_order(order),
      .i_output_gate_n(gate_n), .i_data(dq), .o_data(dq_o), .o_data_oe(oe),
      .i_parity_pins(par), .o_parity_pins(par_o), .o_parity_pins_oe(poe));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      if (fail_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up

   // Hang guard: the whole run needs well under a hundred cycles
   always @(posedge clock)
   begin
      cycles++;
      if (cycles > 2000)
      begin
         fail_count++;
         wrap_up();
      end
   end

   // Data is only judged while the drivers are expected on
   task automatic chk(input logic eo, input logic [17:0] ed);
      checks++;
      if (oe !== eo || poe !== eo || (eo && {par_o, dq_o} !== ed))
      begin
         fail_count++;
         $display("ERROR t=%0t oe %h/%h data %h/%h", $time, oe, eo, {par_o, dq_o}, ed);
      end
   endtask : chk

   // One loaded burst; advances carry junk enables, strobe and address on purpose
   task automatic burst(input logic we, input logic [17:0] a, input int n,
                        input logic ord, input logic part, input logic susp);
      logic [17:0] ad, d, ex, sh;
      logic [1:0]  b;
      ex = '0;
      sh = '0;
      order = ord;
      for (int k = 0; k < n; k++)
      begin
         ad = {a[17:2], ord ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
         b = part ? 2'(k) : 2'b00;
         d = 18'h2_a5c3 ^ {ad[8:0], ad[8:0]} ^ {18{part}};
         if (susp && k == 2)
            repeat (2)
            begin
               sram_ctrl_model_i.cmd(3'b101, 1'b1, 1'b0, 1'b0, 2'b00, ~a, d, 1'b0);
               chk(!gate_n, sh);
            end
         if (k == 0)
            sram_ctrl_model_i.cmd(3'b010, 1'b0, 1'b0, we, b, a, d, !we);
         else
            sram_ctrl_model_i.cmd(3'b101, 1'b0, 1'b1, !we, b, ~a, d, !we);
         if (!we)
         begin
            ex = mem.exists(ad) ? mem[ad] : '0;
            if (!b[0]) {ex[16], ex[7:0]} = {d[16], d[7:0]};
            if (!b[1]) {ex[17], ex[15:8]} = {d[17], d[15:8]};
            mem[ad] = ex;
            chk(1'b0, '0);
         end
         else
         begin
            if (k > 0) chk(!gate_n, ex);
            sh = ex;
            ex = mem[ad];
         end
      end
      sram_ctrl_model_i.cmd(3'b110, 1'b0, 1'b0, 1'b1, 2'h3, a, '0, 1'b0);
      chk(we & !gate_n, ex);
      sram_ctrl_model_i.cmd(3'b000, 1'b0, 1'b0, 1'b1, 2'h3, a, '0, 1'b0);
      chk(1'b0, '0);
      // Advance with nothing to continue must stay deselected
      repeat (2)
         sram_ctrl_model_i.cmd(3'b010, 1'b0, 1'b1, we, 2'h0, a, '0, 1'b0);
      chk(1'b0, '0);
   endtask : burst

   ////////////////////////////////////////////////////////////////////////////////
   task automatic sc_reset();
      chk(1'b0, '0);
   endtask : sc_reset

   task automatic sc_fill();
      burst(1'b0, 18'h0_0101, 4, 1'b1, 1'b0, 1'b0);
   endtask : sc_fill

   task automatic sc_lanes();
      burst(1'b0, 18'h0_0103, 4, 1'b0, 1'b1, 1'b0);
   endtask : sc_lanes

   task automatic sc_read_wrap_suspend();
      burst(1'b1, 18'h0_0101, 6, 1'b0, 1'b0, 1'b1);
   endtask : sc_read_wrap_suspend

   task automatic sc_read_interleave();
      burst(1'b1, 18'h0_0102, 4, 1'b1, 1'b0, 1'b0);
   endtask : sc_read_interleave

   task automatic sc_gate_off();
      gate_n = 1'b1;
      burst(1'b1, 18'h0_0100, 2, 1'b0, 1'b0, 1'b0);
      gate_n = 1'b0;
   endtask : sc_gate_off

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_n = 1'b0;
      gate_n = 1'b0;
      order = 1'b0;
      fail_count = 0;
      checks = 0;
      cycles = 0;
      repeat (6) @(posedge clock);
      #1;
      rst_n = 1'b1;
      sc_reset();
      sc_fill();
      sc_lanes();
      sc_read_wrap_suspend();
      sc_read_interleave();
      sc_gate_off();
      wrap_up();
   end
endmodule : tb_burst_sram_cycle
`default_nettype wire
